/* adcms_defs.vh */
`ifndef ADCMS_DEFS_VH
`define ADCMS_DEFS_VH
// ---------------------------------------------------------------
// Operating modes
// ---------------------------------------------------------------
`define ADCMS_MODE_ONESHOT 3'h0
`define ADCMS_MODE_REPEAT 3'h1
`define ADCMS_MODE_SWEEP 3'h2
`define ADCMS_MODE_RSWEEP0 3'h3
`define ADCMS_MODE_RSWEEP1 3'h4
// ---------------------------------------------------------------
// Extended input select codes
// ---------------------------------------------------------------
`define ADCMS_EXT_NONE 2'h0
`define ADCMS_EXT_IN0 2'h1
`define ADCMS_EXT_IN1 2'h2
// ---------------------------------------------------------------
// Result slots and widths
// ---------------------------------------------------------------
`define ADCMS_SLOT_ZERO 3'h0
`define ADCMS_SLOT_ONE 3'h1
`define ADCMS_RES_W 10
`define ADCMS_RES_RESET 10'h000
// ---------------------------------------------------------------
// Conversion timing, per pin, in converter clock cycles
// ---------------------------------------------------------------
`define ADCMS_CONV_CYCLES_8 8'h31
`define ADCMS_CONV_CYCLES_10 8'h3b
`endif

/* adcms_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcms_dma_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic dma_mode_enable,
   input wire logic [7:0] result_valid,
   input wire logic [79:0] result_bus,
   output logic [31:0] moved,
   output logic [9:0] last
);
   // Moves slot zero out after every conversion while DMA mode is enabled
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         moved <= 32'h0000_0000;
         last <= 10'h000;
      end
      else if (dma_mode_enable && result_valid[0])
      begin
         moved <= moved + 32'h0000_0001;
         last <= result_bus[9:0];
      end
   end
endmodule // adcms_dma_model
`default_nettype wire

/* adcms_seq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcms_defs.vh"
module adcms_seq_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] mode,
   input wire logic resolution_select,
   input wire logic dma_mode_enable,
   input wire logic trigger_source_select,
   input wire logic start_write,
   input wire logic start_write_value,
   input wire logic conversion_start_flag,
   input wire logic busy,
   input wire logic sample_strobe,
   input wire logic irq,
   input wire logic [79:0] result_bus,
   input wire logic [7:0] result_valid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   wire done = result_valid != 8'h00;
   sequence s_stop;
      start_write && !start_write_value;
   endsequence
   sequence s_dma_done;
      done && dma_mode_enable;
   endsequence
   strobe_busy_a: assert property (sample_strobe |-> busy) else $error("strobe without busy");
   conv_time_a: assert property (done |-> (resolution_select ? $past(sample_strobe, 59)
      : $past(sample_strobe, 49))) else $error("conversion length wrong");
   one_slot_a: assert property ($onehot0(result_valid)) else $error("several slots");
   dma_slot_a: assert property (s_dma_done |-> result_valid == 8'h01) else $error("dma slot");
   dma_irq_a: assert property (s_dma_done |-> irq) else $error("dma irq missing");
   no_irq_a: assert property (irq && !dma_mode_enable |-> mode == `ADCMS_MODE_ONESHOT
      || mode == `ADCMS_MODE_SWEEP) else $error("irq in repeat mode");
   stop_halt_a: assert property (s_stop |=> !busy && !conversion_start_flag) else $error("stop");
   soft_clear_a: assert property (done && mode == `ADCMS_MODE_ONESHOT && !trigger_source_select
      |-> !conversion_start_flag && !busy) else $error("one-shot not finished");
   shot_irq_a: assert property (done && mode == `ADCMS_MODE_ONESHOT |-> irq) else $error("no irq");
   repeat_go_a: assert property (done && mode == `ADCMS_MODE_REPEAT |-> sample_strobe)
      else $error("repeat mode stopped");
   low_bits_a: assert property (s_dma_done ##0 !resolution_select |-> result_bus[9:8] == 2'b00)
      else $error("8-bit upper bits set");
endmodule // adcms_seq_assertions
`default_nettype wire

/* adcms_seq_step.v */
`timescale 1ns/1ps
`default_nettype none
`include "adcms_defs.vh"
// ---------------------------------------------------------------
// Next channel of a sweep, and end-of-pass flag
// ---------------------------------------------------------------
module adcms_seq_step (
   input wire [2:0] mode,
   input wire [1:0] sweep_width_select,
   input wire [2:0] channel,
   input wire [2:0] other_ptr,
   input wire prio_phase,
   output reg [2:0] next_channel,
   output reg [2:0] next_other_ptr,
   output reg next_prio_phase,
   output reg pass_done
);
   wire [2:0] last_pin = {sweep_width_select, 1'b1};
   wire [2:0] prio_last = {1'b0, sweep_width_select};

   always @*
   begin
      next_channel = channel;
      next_other_ptr = other_ptr;
      next_prio_phase = prio_phase;
      pass_done = 1'b0;
      if (mode == `ADCMS_MODE_RSWEEP1)
      begin
         // Priority pins, then one other pin, then again
         if (prio_phase)
         begin
            next_channel = 3'h0;
            next_prio_phase = 1'b0;
         end
         else if (channel == prio_last)
         begin
            next_channel = other_ptr;
            next_prio_phase = 1'b1;
            if (other_ptr == 3'h7)
               next_other_ptr = prio_last + 3'h1;
            else
               next_other_ptr = other_ptr + 3'h1;
         end
         else
            next_channel = channel + 3'h1;
      end
      else if (channel == last_pin)
      begin
         next_channel = 3'h0;
         pass_done = 1'b1;
      end
      else
         next_channel = channel + 3'h1;
   end
endmodule // adcms_seq_step
`default_nettype wire

/* adcms_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "adcms_defs.vh"
module adcms_sequencer (
   input wire clk,
   input wire reset,
   input wire [2:0] mode,
   input wire [2:0] channel_select,
   input wire [1:0] extended_input_select,
   input wire [1:0] port_group_select,
   input wire [1:0] sweep_width_select,
   input wire trigger_source_select,
   input wire trigger_kind_select,
   input wire dma_mode_enable,
   input wire resolution_select,
   input wire start_write,
   input wire start_write_value,
   input wire ext_trigger_in,
   input wire motor_timer_b2_event,
   input wire [9:0] sample_code,
   output reg conversion_start_flag,
   output reg busy,
   output reg sample_strobe,
   output reg [1:0] active_group,
   output reg [2:0] active_channel,
   output reg [1:0] active_ext,
   output reg irq,
   output reg [79:0] result_bus,
   output reg [7:0] result_valid
);
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_CONV = 3'b100;

   reg [2:0] state;
   reg [7:0] cycle_cnt;
   reg [2:0] other_ptr;
   reg prio_phase;
   reg trig_meta;
   reg trig_sync;
   reg trig_prev;
   reg tmr_meta;
   reg tmr_sync;
   wire [2:0] step_channel;
   wire [2:0] step_other;
   wire step_prio;
   wire step_pass_done;

   // ------------------------------------------------------------
   // Decoders
   // ------------------------------------------------------------
   function is_sweep_mode;
      input [2:0] m;
      begin
         case (m)
            `ADCMS_MODE_SWEEP,
            `ADCMS_MODE_RSWEEP0,
            `ADCMS_MODE_RSWEEP1:
               is_sweep_mode = 1'b1;
            default:
               is_sweep_mode = 1'b0;
         endcase
      end
   endfunction

   function [2:0] result_slot;
      input dma;
      input [1:0] ext;
      input [2:0] ch;
      begin
         if (dma)
            result_slot = `ADCMS_SLOT_ZERO;
         else if (ext == `ADCMS_EXT_IN0)
            result_slot = `ADCMS_SLOT_ZERO;
         else if (ext == `ADCMS_EXT_IN1)
            result_slot = `ADCMS_SLOT_ONE;
         else
            result_slot = ch;
      end
   endfunction

   function irq_wanted;
      input [2:0] m;
      input dma;
      input pass_end;
      begin
         case (m)
            `ADCMS_MODE_ONESHOT:
               irq_wanted = 1'b1;
            `ADCMS_MODE_SWEEP:
               irq_wanted = dma | pass_end;
            `ADCMS_MODE_REPEAT,
            `ADCMS_MODE_RSWEEP0,
            `ADCMS_MODE_RSWEEP1:
               irq_wanted = dma;
            default:
               irq_wanted = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         // Idle level high, so no false edge
         trig_meta <= 1'b1;
         trig_sync <= 1'b1;
         trig_prev <= 1'b1;
         tmr_meta <= 1'b0;
         tmr_sync <= 1'b0;
      end
      else
      begin
         trig_meta <= ext_trigger_in;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
         tmr_meta <= motor_timer_b2_event;
         tmr_sync <= tmr_meta;
      end
   end

   // ------------------------------------------------------------
   // Trigger qualification
   // ------------------------------------------------------------
   wire ext_fall = trig_prev & ~trig_sync;
   wire hw_trig = trigger_source_select & trigger_kind_select & tmr_sync;
   wire pin_trig = trigger_source_select & ~trigger_kind_select & ext_fall;
   wire any_trig = hw_trig | pin_trig;
   // Stop write wins over every state
   wire stop_req = start_write & ~start_write_value;
   wire start_req = start_write & start_write_value;
   wire soft_start = start_req & ~trigger_source_select;
   // Triggers ignored mid-conversion only in sweep mode 1
   wire retrigger = (state == ST_CONV) && any_trig && (mode != `ADCMS_MODE_RSWEEP1);

   // ------------------------------------------------------------
   // Conversion timing
   // ------------------------------------------------------------
   wire [7:0] conv_len = resolution_select ? `ADCMS_CONV_CYCLES_10 : `ADCMS_CONV_CYCLES_8;
   wire conv_end = (state == ST_CONV) && (cycle_cnt == conv_len - 8'h01);
   wire finish_once = (mode == `ADCMS_MODE_ONESHOT) ||
      ((mode == `ADCMS_MODE_SWEEP) && step_pass_done);

   // ------------------------------------------------------------
   // Input and result routing
   // ------------------------------------------------------------
   wire single_select = (mode == `ADCMS_MODE_ONESHOT) || (mode == `ADCMS_MODE_REPEAT);
   wire [2:0] slot = result_slot(dma_mode_enable, active_ext, active_channel);
   wire [9:0] coded = resolution_select ? sample_code : {2'b00, sample_code[9:2]};

   adcms_seq_step u_step (
      .mode(mode),
      .sweep_width_select(sweep_width_select),
      .channel(active_channel),
      .other_ptr(other_ptr),
      .prio_phase(prio_phase),
      .next_channel(step_channel),
      .next_other_ptr(step_other),
      .next_prio_phase(step_prio),
      .pass_done(step_pass_done)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         conversion_start_flag <= 1'b0;
         busy <= 1'b0;
         sample_strobe <= 1'b0;
         cycle_cnt <= 8'h00;
         active_group <= 2'b00;
         active_channel <= 3'h0;
         active_ext <= `ADCMS_EXT_NONE;
         other_ptr <= 3'h1;
         prio_phase <= 1'b0;
         irq <= 1'b0;
         result_bus <= {80{1'b0}};
         result_valid <= 8'h00;
      end
      else
      begin
         sample_strobe <= 1'b0;
         irq <= 1'b0;
         result_valid <= 8'h00;
         if (stop_req)
         begin
            conversion_start_flag <= 1'b0;
            busy <= 1'b0;
            state <= ST_IDLE;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  if (start_req)
                  begin
                     conversion_start_flag <= 1'b1;
                     active_group <= port_group_select;
                     active_channel <= single_select ? channel_select : 3'h0;
                     active_ext <= single_select ? extended_input_select : `ADCMS_EXT_NONE;
                     // First pin after the priority group
                     other_ptr <= {1'b0, sweep_width_select} + 3'h1;
                     prio_phase <= 1'b0;
                     cycle_cnt <= 8'h00;
                     if (soft_start)
                     begin
                        state <= ST_CONV;
                        busy <= 1'b1;
                        sample_strobe <= 1'b1;
                     end
                     else
                        state <= ST_WAIT;
                  end
               end
               ST_WAIT:
               begin
                  if (any_trig)
                  begin
                     state <= ST_CONV;
                     busy <= 1'b1;
                     sample_strobe <= 1'b1;
                     cycle_cnt <= 8'h00;
                  end
               end
               ST_CONV:
               begin
                  if (retrigger)
                  begin
                     cycle_cnt <= 8'h00;
                     sample_strobe <= 1'b1;
                  end
                  else if (conv_end)
                  begin
                     result_bus[slot*10 +: 10] <= coded;
                     result_valid[slot] <= 1'b1;
                     cycle_cnt <= 8'h00;
                     irq <= irq_wanted(mode, dma_mode_enable, step_pass_done);
                     if (is_sweep_mode(mode))
                     begin
                        active_channel <= step_channel;
                        other_ptr <= step_other;
                        prio_phase <= step_prio;
                     end
                     if (finish_once)
                     begin
                        busy <= 1'b0;
                        if (!trigger_source_select)
                        begin
                           conversion_start_flag <= 1'b0;
                           state <= ST_IDLE;
                        end
                        else
                           state <= ST_WAIT;
                     end
                     else
                        sample_strobe <= 1'b1;
                  end
                  else
                     cycle_cnt <= cycle_cnt + 8'h01;
               end
               default:
                  state <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // adcms_sequencer
`default_nettype wire

/* adcms_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcms_defs.vh"
module adcms_sequencer_bench;
   logic clk = 0, reset = 1, tss = 0, tks = 0, dma = 0, res_sel = 0, sw_en = 0, sw_val = 0;
   logic ext_in = 1, tmr = 0, flag, busy, strobe, irq;
   logic [2:0] mode = 0, chs = 0, ach;
   logic [1:0] exs = 0, pgs = 0, sws = 0, agrp, aext;
   logic [9:0] code = 0, last, dma_exp;
   logic [79:0] rbus;
   logic [7:0] rvalid;
   logic [31:0] moved, lf = 32'h9fb0_63ac;
   logic [9:0] cq[$];
   logic [4:0] chq[$];
   integer fail_count = 0, checked = 0, i, k;
   always #4 clk = ~clk;
   adcms_sequencer u_dut (.clk(clk), .reset(reset), .mode(mode), .channel_select(chs),
      .extended_input_select(exs), .port_group_select(pgs), .sweep_width_select(sws),
      .trigger_source_select(tss), .trigger_kind_select(tks), .dma_mode_enable(dma),
      .resolution_select(res_sel), .start_write(sw_en), .start_write_value(sw_val),
      .ext_trigger_in(ext_in), .motor_timer_b2_event(tmr), .sample_code(code),
      .conversion_start_flag(flag), .busy(busy), .sample_strobe(strobe), .active_group(agrp),
      .active_channel(ach), .active_ext(aext), .irq(irq), .result_bus(rbus),
      .result_valid(rvalid));
   adcms_dma_model u_dma (.clk(clk), .reset(reset), .dma_mode_enable(dma),
      .result_valid(rvalid), .result_bus(rbus), .moved(moved), .last(last));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // New converter code per conversion, remembered with its input
   always @(posedge clk)
   begin
      if (strobe === 1'b1)
      begin
         lf = lfsr(lf);
         code <= lf[9:0];
         cq.push_back(lf[9:0]);
         chq.push_back({aext, ach});
      end
   end
   task report_and_stop;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task cfg(input logic [2:0] m, input logic [1:0] w, input logic d, r, t, kd, input logic [2:0] c);
      @(posedge clk);
      mode <= m;
      sws <= w;
      dma <= d;
      res_sel <= r;
      tss <= t;
      tks <= kd;
      chs <= c;
   endtask
   task sw(input logic v);
      @(posedge clk);
      sw_en <= 1;
      sw_val <= v;
      @(posedge clk);
      sw_en <= 0;
   endtask
   task halt;
      sw(0);
      repeat (3) @(posedge clk);
      cmp(busy, 0);
      cq.delete();
      chq.delete();
   endtask
   task res(input logic [2:0] slot, input logic [4:0] ch, input logic ir);
      integer n;
      logic [9:0] c;
      n = 0;
      @(posedge clk);
      #1;
      while (rvalid === 8'h00 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 200 || cq.size() == 0)
      begin
         fail_count++;
         report_and_stop;
      end
      else
      begin
         c = cq.pop_front();
         if (!res_sel)
            c = {2'b00, c[9:2]};
         if (dma)
            dma_exp = c;
         cmp(rvalid, 8'h01 << slot);
         cmp(rbus[slot * 10 +: 10], c);
         cmp(chq.pop_front(), ch);
         cmp(irq, ir);
      end
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      reset <= 0;
      for (i = 0; i < 8; i++)
      begin
         lf = lfsr(lf);
         cfg(`ADCMS_MODE_ONESHOT, 0, 0, 0, 0, 0, i[2:0]);
         pgs <= lf[1:0];
         sw(1);
         res(i[2:0], {2'b00, i[2:0]}, 1);
         cmp(flag, 0);
         cmp(agrp, pgs);
      end
      pgs <= 0;
      for (i = 1; i < 3; i++)
      begin
         cfg(`ADCMS_MODE_ONESHOT, 0, 0, 1, 0, 0, 0);
         exs <= i[1:0];
         sw(1);
         res(i - 1, {i[1:0], 3'h0}, 1);
      end
      cfg(`ADCMS_MODE_ONESHOT, 0, 1, 1, 0, 0, 5);
      exs <= 0;
      sw(1);
      res(0, 5'h05, 1);
      cfg(`ADCMS_MODE_REPEAT, 0, 0, 1, 0, 0, 3);
      sw(1);
      for (k = 0; k < 3; k++) res(3, 5'h03, 0);
      halt;
      cfg(`ADCMS_MODE_SWEEP, 1, 0, 0, 0, 0, 0);
      sw(1);
      for (k = 0; k < 4; k++) res(k[2:0], k[4:0], k == 3);
      cmp({flag, busy}, 0);
      cfg(`ADCMS_MODE_RSWEEP0, 0, 1, 0, 0, 0, 0);
      sw(1);
      for (k = 0; k < 4; k++) res(0, k % 2, 1);
      halt;
      cfg(`ADCMS_MODE_RSWEEP1, 0, 0, 0, 0, 0, 0);
      sw(1);
      for (k = 0; k < 6; k++) res((k % 2) ? (k + 1) / 2 : 0, (k % 2) ? (k + 1) / 2 : 0, 0);
      halt;
      cfg(`ADCMS_MODE_ONESHOT, 0, 0, 0, 1, 0, 2);
      sw(1);
      repeat (4) @(posedge clk);
      ext_in <= 0;
      repeat (4) @(posedge clk);
      ext_in <= 1;
      res(2, 5'h02, 1);
      cfg(`ADCMS_MODE_ONESHOT, 0, 0, 0, 1, 1, 2);
      @(posedge clk);
      tmr <= 1;
      @(posedge clk);
      tmr <= 0;
      repeat (12) @(posedge clk);
      tmr <= 1;
      @(posedge clk);
      tmr <= 0;
      repeat (8) @(posedge clk);
      cmp(cq.size(), 2);
      void'(cq.pop_front());
      void'(chq.pop_front());
      res(2, 5'h02, 1);
      halt;
      cfg(`ADCMS_MODE_RSWEEP1, 1, 0, 0, 1, 1, 0);
      sw(1);
      for (k = 0; k < 2; k++)
      begin
         tmr <= 1;
         @(posedge clk);
         tmr <= 0;
         repeat (9) @(posedge clk);
      end
      cmp(cq.size(), 1);
      for (k = 0; k < 6; k++) res((k % 3 == 2) ? 2 + k / 3 : k % 3, (k % 3 == 2) ? 2 + k / 3 : k % 3, 0);
      halt;
      cmp(moved, 5);
      cmp(last, dma_exp);
      report_and_stop;
   end
endmodule // adcms_sequencer_bench
bind adcms_sequencer adcms_seq_assertions u_chk (.clk(clk), .reset(reset), .mode(mode),
   .resolution_select(resolution_select), .dma_mode_enable(dma_mode_enable),
   .trigger_source_select(trigger_source_select), .start_write(start_write),
   .start_write_value(start_write_value), .conversion_start_flag(conversion_start_flag),
   .busy(busy), .sample_strobe(sample_strobe), .irq(irq), .result_bus(result_bus),
   .result_valid(result_valid));
`default_nettype wire
